// ---- src/rsel_pkg.sv ----
// Constants, types and register map of the reference selector.
package rsel_pkg;

    localparam int NREF   = 12;
    localparam int NGEN   = 2;
    localparam int AGE_W  = 24;
    localparam int TICK_W = 27;

    // Selection codes: 0 to 11 are reference inputs.
    localparam logic [4:0] CODE_FREERUN  = 5'h10;
    localparam logic [4:0] CODE_HOLDOVER = 5'h11;
    localparam logic [4:0] CODE_PRIMARY_OUT = 5'h12;
    localparam logic [4:0] SLAVE_XREF    = 5'h06;
    localparam logic [3:0] PRIO_OFF      = 4'h0;

    typedef enum logic [1:0] {
        MODE_AUTO      = 2'b00,
        MODE_MANUAL    = 2'b01,
        MODE_HARDWIRED = 2'b10,
        MODE_RSVD      = 2'b11
    } rsel_mode_t;

    typedef enum logic [1:0] {
        GST_FREERUN  = 2'b00,
        GST_SYNC     = 2'b01,
        GST_HOLDOVER = 2'b11
    } rsel_gen_state_t;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_PRIO0L = 8'h04;
    localparam logic [7:0] ADDR_PRIO0H = 8'h08;
    localparam logic [7:0] ADDR_PRIO1L = 8'h0C;
    localparam logic [7:0] ADDR_PRIO1H = 8'h10;
    localparam logic [7:0] ADDR_MANSEL = 8'h14;
    localparam logic [7:0] ADDR_HWSEL  = 8'h18;
    localparam logic [7:0] ADDR_SOAK   = 8'h1C;
    localparam logic [7:0] ADDR_FRAME  = 8'h20;
    localparam logic [7:0] ADDR_QUAL   = 8'h24;
    localparam logic [7:0] ADDR_ELECT  = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;
    localparam logic [7:0] ADDR_MASK   = 8'hFC;

    // Field positions.
    localparam int CTRL_REV_LSB   = 0;
    localparam int CTRL_MODE_LSB  = 2;
    localparam int CTRL_UHIST_BIT = 8;
    localparam int CTRL_BW_LSB    = 16;
    localparam int BW_W           = 10;
    localparam int CODE_W         = 5;
    localparam int GEN1_LSB       = 8;
    localparam int PRIO_PER_WORD  = 8;
    localparam int ST_HIST_BIT    = 0;
    localparam int ST_SLAVE_BIT   = 1;
    localparam int ST_SW_BIT      = 2;
    localparam int ST_GST_LSB     = 8;
    localparam int ST_SEL_LSB     = 16;

    localparam logic [31:0] CTRL_RST = 32'h0064_0003;

    // Bandwidth field counts 0.1 Hz steps.
    localparam int              LOOP_BW_SLAVE_HZ = 100;
    localparam logic [BW_W-1:0] BW_SLAVE_CODE    = BW_W'(LOOP_BW_SLAVE_HZ * 10);

    // Soak time counts whole seconds.
    localparam int CLK_PERIOD_NS   = 8;
    localparam int SOAK_UNIT_MS    = 1000;
    localparam int SOAK_UNIT_CYCLES = SOAK_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : rsel_pkg

// ---- src/rsel_reference_selector.sv ----
// Reference elector and selector for the primary and auxiliary timing generators.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module rsel_reference_selector #(
    parameter int TICK_CYCLES = rsel_pkg::SOAK_UNIT_CYCLES // Cycles per soak second.
) (
    input  wire logic                              aclk,                    // Clock, 125 MHz.
    input  wire logic                              aresetn,                 // Synchronous reset, active low.
    input  wire logic [7:0]                        s_axi_awaddr,            // Write address.
    input  wire logic                              s_axi_awvalid,           // Write address valid.
    output logic                                   s_axi_awready,           // Write address ready.
    input  wire logic [31:0]                       s_axi_wdata,             // Write data.
    input  wire logic [3:0]                        s_axi_wstrb,             // Write byte strobes.
    input  wire logic                              s_axi_wvalid,            // Write data valid.
    output logic                                   s_axi_wready,            // Write data ready.
    output logic [1:0]                             s_axi_bresp,             // Write response.
    output logic                                   s_axi_bvalid,            // Write response valid.
    input  wire logic                              s_axi_bready,            // Write response ready.
    input  wire logic [7:0]                        s_axi_araddr,            // Read address.
    input  wire logic                              s_axi_arvalid,           // Read address valid.
    output logic                                   s_axi_arready,           // Read address ready.
    output logic [31:0]                            s_axi_rdata,             // Read data.
    output logic [1:0]                             s_axi_rresp,             // Read response.
    output logic                                   s_axi_rvalid,            // Read data valid.
    input  wire logic                              s_axi_rready,            // Read data ready.
    input  wire logic [rsel_pkg::NREF-1:0]         ref_active,              // Activity good per reference.
    input  wire logic [rsel_pkg::NREF-1:0]         ref_in_qual_range,       // Offset inside qualification range.
    input  wire logic [rsel_pkg::NREF-1:0]         ref_in_disq_range,       // Offset inside disqualification range.
    input  wire logic                              device_history_valid,    // Device holdover history collected.
    input  wire logic                              source_switch_pin,       // Hard-wired switch pin.
    input  wire logic                              master_slave_select_pin, // High master, low slave.
    input  wire logic                              frame_sync_input,        // External frame reference pin.
    output logic [4:0]                             primary_sel_code,        // Primary selected code.
    output rsel_pkg::rsel_gen_state_t              primary_state,           // Primary generator state.
    output logic [4:0]                             auxiliary_sel_code,      // Auxiliary selected code.
    output rsel_pkg::rsel_gen_state_t              auxiliary_state,         // Auxiliary generator state.
    output logic                                   primary_slave,           // Primary runs as slave.
    output logic [rsel_pkg::BW_W-1:0]              primary_loop_bw,         // Effective bandwidth, 0.1 Hz.
    output logic                                   primary_frame_from_sync, // Frame edges from sync pin.
    output logic                                   frame_edge_pulse,        // Rising edge on sync pin.
    output logic [rsel_pkg::NREF-1:0]              ref_qualified,           // Qualification per reference.
    output logic                                   holdover_history_available // History flag.
);
    import rsel_pkg::*;

    typedef struct packed {
        logic                              awready;
        logic                              wready;
        logic                              bvalid;
        logic                              arready;
        logic                              rvalid;
        logic                              aw_got;
        logic                              w_got;
        logic [7:0]                        waddr;
        logic [31:0]                       wdata;
        logic [3:0]                        wstrb;
        logic [1:0]                        bresp;
        logic [1:0]                        rresp;
        logic [31:0]                       rdata;
        logic [31:0]                       ctrl;
        logic [NGEN-1:0][NREF-1:0][3:0]    prio;
        logic [NGEN-1:0][CODE_W-1:0]       mansel;
        logic [1:0][CODE_W-1:0]            hwsel;
        logic [5:0]                        soak;
        logic [NREF-1:0]                   frame_info;
        logic [1:0]                        sw_sync;
        logic [1:0]                        ms_sync;
        logic [2:0]                        fs_sync;
        logic [TICK_W-1:0]                 tick_cnt;
        logic                              tick;
        logic [NREF-1:0][6:0]              soak_cnt;
        logic [NREF-1:0]                   qual;
        logic [NREF-1:0][AGE_W-1:0]        age;
        logic [NGEN-1:0][CODE_W-1:0]       cand;
        logic [NGEN-1:0][CODE_W-1:0]       sel;
        rsel_gen_state_t [NGEN-1:0]        gst;
        logic                              slave;
        logic [BW_W-1:0]                   bw;
        logic                              frame_ext;
        logic                              frame_edge;
        logic                              hist_avail;
    } rsel_state_t;

    rsel_state_t q;
    rsel_state_t d;

    function automatic logic [31:0] rsel_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : rsel_merge

    function automatic logic rsel_mapped(input logic [7:0] a);
        return (a & ADDR_MASK) <= ADDR_STATUS;
    endfunction : rsel_mapped

    // Priority words: low word holds references 0 to 7, high word 8 to 11.
    function automatic logic [31:0] rsel_prio_word(input logic [NREF-1:0][3:0] p, input logic hi);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int r = 0; r < NREF; r++) begin
            if ((r >= PRIO_PER_WORD) == hi) begin
                w[4*(r % PRIO_PER_WORD) +: 4] = p[r];
            end
        end
        return w;
    endfunction : rsel_prio_word

    always_comb begin
        logic [31:0]      wmerged;
        logic [31:0]      rword;
        logic [7:0]       wa;
        logic             best_ok;
        logic [3:0]       best_p;
        logic [AGE_W-1:0] best_age;
        logic [CODE_W-1:0] best_code;
        logic             cur_ok;
        logic [3:0]       cur_p;
        logic [CODE_W-1:0] code;
        logic             legal;
        rsel_mode_t       mode;
        wmerged   = 32'h0000_0000;
        rword     = 32'h0000_0000;
        wa        = 8'h00;
        best_ok   = 1'b0;
        best_p    = 4'hF;
        best_age  = '0;
        best_code = CODE_FREERUN;
        cur_ok    = 1'b0;
        cur_p     = 4'hF;
        code      = CODE_FREERUN;
        legal     = 1'b0;
        mode      = MODE_AUTO;
        d = q;

        // Pin synchronisers; logic reads the second stage, and the frame edge detector also the third.
        d.sw_sync = {q.sw_sync[0], source_switch_pin};
        d.ms_sync = {q.ms_sync[0], master_slave_select_pin};
        d.fs_sync = {q.fs_sync[1:0], frame_sync_input};
        d.frame_edge = q.fs_sync[1] & ~q.fs_sync[2];

        // Write channel.
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            wa = q.waddr & ADDR_MASK;
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = rsel_mapped(q.waddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (wa)
                ADDR_CTRL: begin
                    d.ctrl = rsel_merge(q.ctrl, q.wdata, q.wstrb);
                end
                ADDR_PRIO0L, ADDR_PRIO0H, ADDR_PRIO1L, ADDR_PRIO1H: begin
                    for (int g = 0; g < NGEN; g++) begin
                        for (int r = 0; r < NREF; r++) begin
                            if (wa == (r < PRIO_PER_WORD ? (g == 0 ? ADDR_PRIO0L : ADDR_PRIO1L)
                                                         : (g == 0 ? ADDR_PRIO0H : ADDR_PRIO1H))) begin
                                wmerged = rsel_merge(rsel_prio_word(q.prio[g], r >= PRIO_PER_WORD), q.wdata, q.wstrb);
                                d.prio[g][r] = wmerged[4*(r % PRIO_PER_WORD) +: 4];
                            end
                        end
                    end
                end
                ADDR_MANSEL: begin
                    wmerged = rsel_merge({19'h0, q.mansel[1], 3'h0, q.mansel[0]}, q.wdata, q.wstrb);
                    d.mansel[0] = wmerged[CODE_W-1:0];
                    d.mansel[1] = wmerged[GEN1_LSB +: CODE_W];
                end
                ADDR_HWSEL: begin
                    wmerged = rsel_merge({19'h0, q.hwsel[1], 3'h0, q.hwsel[0]}, q.wdata, q.wstrb);
                    d.hwsel[0] = wmerged[CODE_W-1:0];
                    d.hwsel[1] = wmerged[GEN1_LSB +: CODE_W];
                end
                ADDR_SOAK: begin
                    wmerged = rsel_merge({26'h0, q.soak}, q.wdata, q.wstrb);
                    d.soak = wmerged[5:0];
                end
                ADDR_FRAME: begin
                    wmerged = rsel_merge({20'h0, q.frame_info}, q.wdata, q.wstrb);
                    d.frame_info = wmerged[NREF-1:0];
                end
                default: begin
                end
            endcase
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready  = !d.w_got && !d.bvalid;

        // Read channel.
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            unique case (s_axi_araddr & ADDR_MASK)
                ADDR_CTRL:   rword = q.ctrl;
                ADDR_PRIO0L: rword = rsel_prio_word(q.prio[0], 1'b0);
                ADDR_PRIO0H: rword = rsel_prio_word(q.prio[0], 1'b1);
                ADDR_PRIO1L: rword = rsel_prio_word(q.prio[1], 1'b0);
                ADDR_PRIO1H: rword = rsel_prio_word(q.prio[1], 1'b1);
                ADDR_MANSEL: rword = {19'h0, q.mansel[1], 3'h0, q.mansel[0]};
                ADDR_HWSEL:  rword = {19'h0, q.hwsel[1], 3'h0, q.hwsel[0]};
                ADDR_SOAK:   rword = {26'h0, q.soak};
                ADDR_FRAME:  rword = {20'h0, q.frame_info};
                ADDR_QUAL:   rword = {20'h0, q.qual};
                ADDR_ELECT:  rword = {19'h0, q.cand[1], 3'h0, q.cand[0]};
                ADDR_STATUS: begin
                    rword[ST_HIST_BIT]  = q.hist_avail;
                    rword[ST_SLAVE_BIT] = q.slave;
                    rword[ST_SW_BIT]    = q.sw_sync[1];
                    rword[ST_GST_LSB +: 4] = {q.gst[1], q.gst[0]};
                    rword[ST_SEL_LSB +: 13] = {q.sel[1], 3'h0, q.sel[0]};
                end
                default: rword = 32'h0000_0000;
            endcase
            d.rdata  = rword;
            d.rresp  = rsel_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            d.rvalid = 1'b1;
        end
        d.arready = !d.rvalid;

        // Qualification: soak seconds counted from a prescaled tick.
        d.tick     = (q.tick_cnt == TICK_W'(TICK_CYCLES - 1));
        d.tick_cnt = d.tick ? '0 : q.tick_cnt + 1'b1;
        for (int r = 0; r < NREF; r++) begin
            if (!ref_active[r] || !ref_in_disq_range[r]) begin
                d.qual[r]     = 1'b0;
                d.soak_cnt[r] = '0;
            end else if (!q.qual[r]) begin
                if (!ref_active[r] || !ref_in_qual_range[r]) begin
                    d.soak_cnt[r] = '0;
                end else if (q.soak_cnt[r] > {1'b0, q.soak}) begin
                    d.qual[r] = 1'b1;
                end else if (q.tick) begin
                    d.soak_cnt[r] = q.soak_cnt[r] + 1'b1;
                end
            end
            // Age saturates; ties beyond it fall back to the lower index.
            if (!q.qual[r]) begin
                d.age[r] = '0;
            end else if (q.age[r] != {AGE_W{1'b1}}) begin
                d.age[r] = q.age[r] + 1'b1;
            end
        end

        d.hist_avail = q.ctrl[CTRL_UHIST_BIT] | device_history_valid;
        d.slave = ~q.ms_sync[1];

        // Elector per generator, every cycle, regardless of mode.
        for (int g = 0; g < NGEN; g++) begin
            best_ok   = 1'b0;
            best_p    = 4'hF;
            best_age  = '0;
            best_code = CODE_FREERUN;
            cur_ok    = 1'b0;
            cur_p     = 4'hF;
            for (int r = 0; r < NREF; r++) begin
                if (q.qual[r] && q.prio[g][r] != PRIO_OFF) begin
                    if (!best_ok || q.prio[g][r] < best_p ||
                        (q.prio[g][r] == best_p && q.age[r] > best_age)) begin
                        best_ok   = 1'b1;
                        best_p    = q.prio[g][r];
                        best_age  = q.age[r];
                        best_code = CODE_W'(r);
                    end
                end
                if (q.cand[g] == CODE_W'(r)) begin
                    cur_ok = q.qual[r] && q.prio[g][r] != PRIO_OFF;
                    cur_p  = q.prio[g][r];
                end
            end
            if (cur_ok) begin
                if (q.ctrl[CTRL_REV_LSB + g] && best_ok && best_p < cur_p) begin
                    d.cand[g] = best_code;
                end
                // Non-revertive keeps a still qualified candidate.
            end else if (best_ok) begin
                d.cand[g] = best_code;
            end else begin
                d.cand[g] = q.hist_avail ? CODE_HOLDOVER : CODE_FREERUN;
            end

            // Selection by mode.
            mode = rsel_mode_t'(q.ctrl[CTRL_MODE_LSB + 2*g +: 2]);
            unique case (mode)
                MODE_MANUAL: code = q.mansel[g];
                MODE_HARDWIRED: begin
                    if (g == 0) begin
                        code = q.sw_sync[1] ? q.hwsel[1] : q.hwsel[0];
                    end else begin
                        code = q.cand[g];
                    end
                end
                default: code = q.cand[g];
            endcase
            legal = code < CODE_W'(NREF) || code == CODE_FREERUN || code == CODE_HOLDOVER ||
                    (code == CODE_PRIMARY_OUT && g == 1 && mode == MODE_MANUAL);
            if (!legal) begin
                code = CODE_FREERUN;
            end
            if (g == 0 && q.slave) begin
                code = SLAVE_XREF;
            end
            d.sel[g] = code;
            if (code == CODE_HOLDOVER) begin
                d.gst[g] = GST_HOLDOVER;
            end else if (code == CODE_FREERUN) begin
                d.gst[g] = GST_FREERUN;
            end else begin
                d.gst[g] = GST_SYNC;
            end
        end

        d.bw = q.slave ? BW_SLAVE_CODE : q.ctrl[CTRL_BW_LSB +: BW_W];
        d.frame_ext = 1'b0;
        for (int r = 0; r < NREF; r++) begin
            if (q.sel[0] == CODE_W'(r)) begin
                d.frame_ext = ~q.frame_info[r];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q        <= '0;
            q.ctrl   <= CTRL_RST;
            q.mansel <= {CODE_FREERUN, CODE_FREERUN};
            q.hwsel  <= {CODE_FREERUN, CODE_FREERUN};
            q.cand   <= {CODE_FREERUN, CODE_FREERUN};
            q.sel    <= {CODE_FREERUN, CODE_FREERUN};
            // The role synchroniser starts at the master level, so no false slave spell follows reset.
            q.ms_sync <= '1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready              = q.awready;
    assign s_axi_wready               = q.wready;
    assign s_axi_bresp                = q.bresp;
    assign s_axi_bvalid               = q.bvalid;
    assign s_axi_arready              = q.arready;
    assign s_axi_rdata                = q.rdata;
    assign s_axi_rresp                = q.rresp;
    assign s_axi_rvalid               = q.rvalid;
    assign primary_sel_code           = q.sel[0];
    assign primary_state              = q.gst[0];
    assign auxiliary_sel_code         = q.sel[1];
    assign auxiliary_state            = q.gst[1];
    assign primary_slave              = q.slave;
    assign primary_loop_bw            = q.bw;
    assign primary_frame_from_sync    = q.frame_ext;
    assign frame_edge_pulse           = q.frame_edge;
    assign ref_qualified              = q.qual;
    assign holdover_history_available = q.hist_avail;

endmodule : rsel_reference_selector

// ---- tb/rsel_monitor.sv ----
// Port-level assertions for the reference selector.
`timescale 1ns/10ps
module rsel_monitor import rsel_pkg::*; (
    input wire logic aclk, aresetn, master_slave_select_pin, frame_sync_input, // Clock, reset, pins.
    input wire logic device_history_valid, holdover_history_available, frame_edge_pulse, primary_slave, // Flags.
    input wire logic [4:0]      primary_sel_code, // Primary code.
    input wire rsel_gen_state_t primary_state,    // Primary state.
    input wire logic [BW_W-1:0] primary_loop_bw,  // Bandwidth.
    input wire logic [NREF-1:0] ref_active, ref_qualified); // Qualification.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // The role pin crosses a synchroniser, so it must be steady a while before the role is judged.
    a_master_role: assert property (master_slave_select_pin [*4] |-> !primary_slave) else $error("role");
    a_slave_bw: assert property ($rose(primary_slave) |-> ##[0:2] primary_loop_bw == BW_SLAVE_CODE) else $error("bw");
    a_slave_sel: assert property ($rose(primary_slave) |-> ##[0:3] primary_sel_code == SLAVE_XREF) else $error("xref");
    a_hist_flag: assert property (device_history_valid |=> holdover_history_available) else $error("hist");
    a_frame_edge: assert property ($rose(frame_sync_input) |-> ##[2:4] frame_edge_pulse) else $error("edge");
    a_hold_state: assert property ((primary_sel_code == CODE_HOLDOVER) == (primary_state == GST_HOLDOVER)) else $error("st");
    a_qual_drop: assert property (1'b1 |=> (ref_qualified & ~$past(ref_active)) == '0) else $error("qual");
    a_no_feedback: assert property (primary_sel_code != CODE_PRIMARY_OUT) else $error("feedback");
endmodule : rsel_monitor

// ---- tb/rsel_peer.sv ----
// Peer synchronizer on the redundancy link: role pin and frame reference.
`timescale 1ns/10ps
module rsel_peer (
    input  wire logic aclk,                    // Clock.
    input  wire logic be_master,               // Role the unit is told to take.
    output logic      master_slave_select_pin, // Role pin.
    output logic      frame_sync_input);       // Frame reference.
    logic [3:0] cnt_q = 4'h0;
    assign master_slave_select_pin = be_master;
    // A short pulse every sixteen cycles stands in for the master's frame clock.
    always_ff @(posedge aclk) begin
        cnt_q <= cnt_q + 4'h1;
        frame_sync_input <= (cnt_q < 4'h3);
    end
endmodule : rsel_peer

// ---- tb/rsel_reference_selector_bench.sv ----
// Self-checking bench for the reference selector.
`timescale 1ns/10ps
module rsel_reference_selector_bench;
    import rsel_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, device_history_valid = 0, source_switch_pin = 0, be_master = 1, master_slave_select_pin;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, frame_sync_input, primary_slave;
    logic primary_frame_from_sync, frame_edge_pulse, holdover_history_available;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [4:0] primary_sel_code, auxiliary_sel_code;
    rsel_gen_state_t primary_state, auxiliary_state;
    logic [BW_W-1:0] primary_loop_bw;
    logic [NREF-1:0] ref_active = '1, ref_in_qual_range = '1, ref_in_disq_range = '1, ref_qualified;
    logic [63:0] w;
    int bad_count = 0, cmp_count = 0, n, p[12];
    int unsigned seed = 31740;
    always #4 aclk = ~aclk;
    rsel_reference_selector #(.TICK_CYCLES(4)) uut (.*);
    rsel_peer peer (.*);
    function automatic int unsigned rnd();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Equal ages after a common qualification edge, so a tie goes to the lower index.
    function automatic logic [4:0] best(input int q[12]);
        int b = -1;
        for (int i = 0; i < 12; i++) if (q[i] != 0 && (b < 0 || q[i] < q[b])) b = i;
        return (b < 0) ? CODE_FREERUN : 5'(b);
    endfunction : best
    task automatic end_sim;
        $display("Comparisons %0d, errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin bad_count++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin @(posedge aclk); n++; if (s_axi_awready) s_axi_awvalid <= 0; if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid && n < 200);
        r = s_axi_bresp; s_axi_bready <= 0;
        if (n >= 200) begin bad_count++; end_sim(); end
        repeat (4) @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin @(posedge aclk); n++; if (s_axi_arready) s_axi_arvalid <= 0; end while (!s_axi_rvalid && n < 200);
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
        if (n >= 200) begin bad_count++; end_sim(); end
    endtask : rd
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(ADDR_CTRL); chk(d, CTRL_RST);
        rd(8'h40); chk(32'(r), 32'(RESP_SLVERR));
        wr(8'h40, 0); chk(32'(r), 32'(RESP_SLVERR));
        repeat (20) @(posedge aclk);
        for (int k = 0; k < 6; k++) begin
            device_history_valid <= k[0];
            wr(ADDR_PRIO0L, 0); wr(ADDR_PRIO0H, 0);
            chk(32'(primary_sel_code), k[0] ? 32'(CODE_HOLDOVER) : 32'(CODE_FREERUN));
            w = 0;
            for (int i = 0; i < 12; i++) begin p[i] = rnd() % 16; w |= 64'(p[i]) << (4 * i); end
            wr(ADDR_PRIO0L, w[31:0]); wr(ADDR_PRIO0H, w[63:32]);
            if (best(p) != CODE_FREERUN) chk(32'(primary_sel_code), 32'(best(p)));
            rd(ADDR_ELECT); if (best(p) != CODE_FREERUN) chk(32'(d[4:0]), 32'(best(p)));
        end
        device_history_valid <= 0;
        wr(ADDR_PRIO0H, 0); wr(ADDR_PRIO0L, 32'h0005_0000); wr(ADDR_CTRL, 32'h0064_0002);
        wr(ADDR_PRIO0L, 32'h0005_0010); chk(32'(primary_sel_code), 4);
        ref_active[4] <= 0; repeat (4) @(posedge aclk); chk(32'(primary_sel_code), 1); chk(32'(ref_qualified), 32'hFEF);
        // Reference 1 re-soaks, so on a tie reference 7 has been qualified longer.
        ref_active[1] <= 0; repeat (4) @(posedge aclk); ref_active[1] <= 1; wr(ADDR_PRIO0L, 0);
        wr(ADDR_PRIO0L, 32'h1000_0010); chk(32'(primary_sel_code), 7);
        wr(ADDR_CTRL, 32'h0064_0017); wr(ADDR_MANSEL, 32'h0000_1209);
        chk(32'(primary_sel_code), 9); chk(32'(auxiliary_sel_code), 32'(CODE_PRIMARY_OUT));
        wr(ADDR_MANSEL, 32'h11); chk(32'(primary_state), 32'(GST_HOLDOVER)); chk(32'(auxiliary_state), 32'(GST_SYNC));
        wr(ADDR_CTRL, 32'h0064_0028); wr(ADDR_HWSEL, 32'h0000_1003);
        for (int s = 0; s < 2; s++) begin
            source_switch_pin <= s[0]; repeat (6) @(posedge aclk);
            chk(32'(primary_sel_code), s ? 32'(CODE_FREERUN) : 3);
            chk(32'(auxiliary_sel_code), 32'(CODE_FREERUN));
        end
        wr(ADDR_CTRL, 32'h0064_0003); be_master <= 0; repeat (10) @(posedge aclk);
        chk(32'(primary_loop_bw), 32'(BW_SLAVE_CODE)); chk(32'(primary_sel_code), 32'(SLAVE_XREF));
        chk(32'(primary_frame_from_sync), 1);
        end_sim();
    end
endmodule : rsel_reference_selector_bench
bind rsel_reference_selector rsel_monitor mon (.*);
